// File: csie_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef CSIE_REGS_SVH
`define CSIE_REGS_SVH

`define CSIE_OFS_LEG_FLAGS   12'h004
`define CSIE_OFS_LEG_MASKS   12'h005
`define CSIE_OFS_GLB_CTRL    12'h01e
`define CSIE_OFS_ROUTE       12'h08c
`define CSIE_OFS_FUNC_FLAG   12'h091
`define CSIE_OFS_SOCK_EVENT  12'h100
`define CSIE_OFS_SOCK_MASK   12'h104

`define CSIE_LEG_BATTERY_DETECT_ONE        0
`define CSIE_LEG_BATTERY_DETECT_TWO        1
`define CSIE_LEG_READY       2
`define CSIE_LEG_PWR         3
`define CSIE_SOCK_IO_CARD_STATUS_CHANGED     0
`define CSIE_SOCK_CD1        1
`define CSIE_SOCK_CD2        2
`define CSIE_SOCK_PWR        3
`define CSIE_GLB_W1C_BIT     2
`define CSIE_FUNC_BIT        0

`define CSIE_RT_MODE_LSB     0
`define CSIE_RT_PTERM_LSB    4
`define CSIE_RT_SFUNC_LSB    8
`define CSIE_RT_SCSC_LSB     12

`define CSIE_LEG_MASK_RST    8'h00
`define CSIE_GLB_CTRL_RST    8'h00
`define CSIE_SOCK_MASK_RST   32'h00000000
`define CSIE_ROUTE_RST       32'h00000003

`define CSIE_TERM_INTA       0
`define CSIE_TERM_SERIAL     3
`define CSIE_SER_SLOTS       5'd17
`define CSIE_SER_INTA_SLOT   5'd16
`define CSIE_CLK_MHZ         40
`define CSIE_SER_SLOT_NS     125
`define CSIE_SER_SLOT_CYC    ((`CSIE_SER_SLOT_NS * `CSIE_CLK_MHZ) / 1000)

`endif

// File: csie_pkg.sv
// types shared by the card slot interrupt event block
package csie_pkg;

  typedef enum logic [1:0] {
    CT_NONE,
    CT_MEM16,
    CT_IO16,
    CT_CARDBUS
  } csie_card_type_e;

  typedef enum logic [1:0] {
    SIG_PAR_PCI,
    SIG_PAR_IRQ,
    SIG_SER_IRQ,
    SIG_SER_ALL
  } csie_sig_mode_e;

  typedef struct packed {
    logic card_detect_one;
    logic card_detect_two;
    logic battery_detect_one;
    logic battery_detect_two;
    logic ready_irq;
  } csie_card_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csie_req_s;

  typedef struct packed {
    csie_sig_mode_e mode;
    logic [2:0]     par_term;
    logic [3:0]     ser_func_irq;
    logic [3:0]     ser_csc_irq;
  } csie_route_s;

endpackage

// File: csie_sync_edge.sv
// two-stage synchroniser with level, change and rise outputs
`timescale 1ns/1ps
module csie_sync_edge #(
  parameter int W = 5
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_change,
  output logic      [W-1:0] o_rise
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;

  // meta_r feeds sync_r only; edges are taken between sync_r and prev_r
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
          prev_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= i_async[g];
          sync_r[g] <= meta_r[g];
          prev_r[g] <= sync_r[g];
        end
      end
      assign o_change[g] = sync_r[g] ^ prev_r[g];
      assign o_rise[g]   = sync_r[g] & ~prev_r[g];
    end
  endgenerate

  assign o_level = sync_r;

endmodule

// File: csie_host_route.sv
// steers status-change and functional requests onto the seven terminals
`timescale 1ns/1ps
module csie_host_route
  import csie_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_csc,
  input  wire logic        i_func,
  input  csie_pkg::csie_route_s i_route,
  output logic      [6:0]  o_terms
);

`include "csie_regs.svh"

  logic [15:0] div_r;
  logic [4:0]  slot_r;
  logic [6:0]  terms_r;
  logic [6:0]  terms_nxt;
  logic        slot_en;
  logic        par_pci;
  logic        ser_on;
  logic        ser_bit;
  logic        inta_req;
  logic [15:0] ser_irqs;

  function automatic logic [15:0] irq_onehot(input logic [3:0] n);
    irq_onehot = 16'h0001 << n;
  endfunction

  assign slot_en  = (div_r == 16'((`CSIE_SER_SLOT_CYC) - 1));
  assign par_pci  = (i_route.mode != SIG_SER_ALL);
  assign ser_on   = (i_route.mode == SIG_SER_IRQ) ||
                    (i_route.mode == SIG_SER_ALL);
  // csc rides INTA unless everything is serialised
  assign inta_req = i_csc ||
                    (i_func && (i_route.mode == SIG_PAR_PCI));
  assign ser_irqs = (i_func ? irq_onehot(i_route.ser_func_irq) : 16'h0000) |
                    ((i_csc && !par_pci) ?
                     irq_onehot(i_route.ser_csc_irq) : 16'h0000);
  // slot 0 is the start slot; a request shows as a low slot
  assign ser_bit  = (slot_r == 5'd0) ? 1'b0 :
                    (slot_r == `CSIE_SER_INTA_SLOT) ? 1'b1 :
                    ~ser_irqs[slot_r[3:0]];

  always_comb begin
    terms_nxt = 7'h00;
    terms_nxt[`CSIE_TERM_INTA] = par_pci ? ~inta_req : 1'b1; // R02 R03
    if (i_route.mode == SIG_PAR_IRQ && i_route.par_term != 3'd0) begin
      terms_nxt[i_route.par_term] = i_func; // R03
    end
    if (ser_on) begin
      terms_nxt[`CSIE_TERM_SERIAL] = ser_bit; // R03
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r   <= 16'h0000;
      slot_r  <= 5'h00;
      terms_r <= 7'h01;
    end else begin
      div_r   <= slot_en ? 16'h0000 : div_r + 16'h0001;
      if (slot_en) begin
        slot_r <= (slot_r == `CSIE_SER_SLOTS - 5'd1) ? 5'h00 :
                  slot_r + 5'h01;
      end
      terms_r <= terms_nxt;
    end
  end

  assign o_terms = terms_r;

endmodule

// File: csie_top.sv
// card slot interrupt event detection, flags, masks and register access
`timescale 1ns/1ps

// Operation
// R01: each socket interrupt is a status-change event or a functional request.
// R02: all host signalling leaves through the seven multifunction terminals.
// R03: parallel PCI, parallel ISA or serialized; PCI combines with either.
// R04: functional requests only for 16-bit I/O or CardBus, never memory.
// R05: either card-detect transition raises insertion/removal, any card type.
// R06: memory card battery-detect transitions set legacy flags 1 and 0.
// R07: memory card ready transition sets legacy flag bit 2.
// R08: I/O card status-changed assertion sets legacy flag bit 0.
// R09: I/O card irq request is unmasked functional request, 91h bit 0.
// R10: CardBus status-change assertion sets socket event bit 0.
// R11: CardBus card irq is unmasked functional request, 91h bit 0.
// R12: power-up complete sets bit 3: legacy for 16-bit, socket for CardBus.
// R13: CardBus insertion/removal masked and flagged in socket bits 2 and 1.
// R14: all but functional requests maskable; every source has a flag.
// R15: legacy flags clear on read or by write-one, chosen by global bit 2.
// R16: socket event flags clear only by writing one.
// R17: host interrupt held while enabled flag or functional request pends.
// R18: socket inputs synchronised before edge detection; one flag per edge.
module csie_top
  import csie_pkg::*;
(
  input  wire logic                     I_CLK,
  input  wire logic                     I_SYS_RST,
  input  csie_pkg::csie_card_s          I_CARD,
  input  csie_pkg::csie_card_type_e     I_CARD_TYPE,
  input  wire logic                     I_PWR_CYCLE_DONE,
  input  csie_pkg::csie_req_s           I_REG_REQ,
  output logic [31:0]                   O_REG_RDATA,
  output logic                          O_REG_RVALID,
  output logic [6:0]                    O_MULTIFUNCTION_TERMINALS
);

`include "csie_regs.svh"

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [4:0]  pin_level;
  logic [4:0]  pin_change;
  logic [4:0]  pin_rise;

  logic [3:0]  leg_flags_r;
  logic [3:0]  leg_flags_nxt;
  logic [7:0]  leg_masks_r;
  logic [7:0]  glb_ctrl_r;
  logic [3:0]  sock_flags_r;
  logic [3:0]  sock_flags_nxt;
  logic [31:0] sock_masks_r;
  logic [31:0] route_r;
  logic        func_r;
  logic        csc_r;
  logic [31:0] rdata_r;
  logic        rvalid_r;

  logic        is_mem;
  logic        is_io;
  logic        is_cb;
  logic        is_16;
  logic [3:0]  leg_set;
  logic [3:0]  leg_clr;
  logic [3:0]  sock_set;
  logic [3:0]  sock_clr;
  logic        leg_w1c;
  logic        func_nxt;
  logic        csc_nxt;
  logic [31:0] rd_mux;
  csie_route_s route;

  logic        hit_leg_flags;
  logic        hit_leg_masks;
  logic        hit_glb;
  logic        hit_route;
  logic        hit_func;
  logic        hit_sock_ev;
  logic        hit_sock_mk;

  localparam int P_CD1  = 4;
  localparam int P_CD2  = 3;
  localparam int P_BATTERY_DETECT_ONE = 2;
  localparam int P_BATTERY_DETECT_TWO = 1;
  localparam int P_RDY  = 0;

  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] ofs);
    addr_is = (a == ofs);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // card pin synchronisation

  csie_sync_edge #(
    .W (5)
  ) u_sync (
    .i_clk    (I_CLK),
    .i_rst    (I_SYS_RST),
    .i_async  (I_CARD), // R18
    .o_level  (pin_level),
    .o_change (pin_change),
    .o_rise   (pin_rise)
  );

  //////////////////////////////////////////////////////////////////////////////
  // card type qualification

  assign is_mem = (I_CARD_TYPE == CT_MEM16);
  assign is_io  = (I_CARD_TYPE == CT_IO16);
  assign is_cb  = (I_CARD_TYPE == CT_CARDBUS);
  assign is_16  = is_mem | is_io;

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  assign hit_leg_flags = addr_is(I_REG_REQ.addr, `CSIE_OFS_LEG_FLAGS);
  assign hit_leg_masks = addr_is(I_REG_REQ.addr, `CSIE_OFS_LEG_MASKS);
  assign hit_glb       = addr_is(I_REG_REQ.addr, `CSIE_OFS_GLB_CTRL);
  assign hit_route     = addr_is(I_REG_REQ.addr, `CSIE_OFS_ROUTE);
  assign hit_func      = addr_is(I_REG_REQ.addr, `CSIE_OFS_FUNC_FLAG);
  assign hit_sock_ev   = addr_is(I_REG_REQ.addr, `CSIE_OFS_SOCK_EVENT);
  assign hit_sock_mk   = addr_is(I_REG_REQ.addr, `CSIE_OFS_SOCK_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // status-change event sources, split from functional requests

  // shared pin: battery detect one on memory cards, status change otherwise
  assign leg_set[`CSIE_LEG_BATTERY_DETECT_ONE]  = (is_mem & pin_change[P_BATTERY_DETECT_ONE]) | // R06
                                    (is_io & pin_rise[P_BATTERY_DETECT_ONE]); // R08
  assign leg_set[`CSIE_LEG_BATTERY_DETECT_TWO]  = is_mem & pin_change[P_BATTERY_DETECT_TWO]; // R06
  assign leg_set[`CSIE_LEG_READY] = is_mem & pin_change[P_RDY]; // R07
  assign leg_set[`CSIE_LEG_PWR]   = is_16 & I_PWR_CYCLE_DONE; // R12

  assign sock_set[`CSIE_SOCK_IO_CARD_STATUS_CHANGED] = is_cb & pin_rise[P_BATTERY_DETECT_ONE]; // R10
  // detect pins are watched for any card type, even with no card present
  assign sock_set[`CSIE_SOCK_CD1] = pin_change[P_CD1]; // R05 R13
  assign sock_set[`CSIE_SOCK_CD2] = pin_change[P_CD2]; // R05 R13
  assign sock_set[`CSIE_SOCK_PWR] = is_cb & I_PWR_CYCLE_DONE; // R12

  //////////////////////////////////////////////////////////////////////////////
  // flag clearing

  assign leg_w1c = glb_ctrl_r[`CSIE_GLB_W1C_BIT];
  assign leg_clr = leg_w1c ?
                   ((I_REG_REQ.wr && hit_leg_flags) ?
                    I_REG_REQ.wdata[3:0] : 4'h0) :
                   ((I_REG_REQ.rd && hit_leg_flags) ? 4'hf : 4'h0); // R15
  assign sock_clr = (I_REG_REQ.wr && hit_sock_ev) ?
                    I_REG_REQ.wdata[3:0] : 4'h0; // R16

  // a new event in the clearing cycle survives the clear
  assign leg_flags_nxt  = (leg_flags_r & ~leg_clr) | leg_set; // R15
  assign sock_flags_nxt = (sock_flags_r & ~sock_clr) | sock_set; // R16

  //////////////////////////////////////////////////////////////////////////////
  // functional request and host request summary

  // no mask exists for functional requests; memory cards never raise them
  assign func_nxt = (is_io | is_cb) & pin_level[P_RDY]; // R04 R09 R11 R01

  assign csc_nxt = |(leg_flags_r & leg_masks_r[3:0]) |
                   |(sock_flags_r & sock_masks_r[3:0]); // R14 R17 R01

  //////////////////////////////////////////////////////////////////////////////
  // read data

  assign rd_mux = hit_leg_flags ? {28'h0, leg_flags_r} :
                  hit_leg_masks ? {24'h0, leg_masks_r} :
                  hit_glb       ? {24'h0, glb_ctrl_r} :
                  hit_route     ? route_r :
                  hit_func      ? {31'h0, func_r} :
                  hit_sock_ev   ? {28'h0, sock_flags_r} :
                  hit_sock_mk   ? sock_masks_r :
                  32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      leg_flags_r  <= 4'h0;
      sock_flags_r <= 4'h0;
      func_r       <= 1'b0;
      csc_r        <= 1'b0;
    end else begin
      leg_flags_r  <= leg_flags_nxt;
      sock_flags_r <= sock_flags_nxt;
      func_r       <= func_nxt;
      csc_r        <= csc_nxt;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      leg_masks_r  <= `CSIE_LEG_MASK_RST;
      glb_ctrl_r   <= `CSIE_GLB_CTRL_RST;
      sock_masks_r <= `CSIE_SOCK_MASK_RST;
      route_r      <= `CSIE_ROUTE_RST;
    end else if (I_REG_REQ.wr) begin
      if (hit_leg_masks) begin
        leg_masks_r <= I_REG_REQ.wdata[7:0]; // R14
      end
      if (hit_glb) begin
        glb_ctrl_r <= I_REG_REQ.wdata[7:0];
      end
      if (hit_sock_mk) begin
        sock_masks_r <= I_REG_REQ.wdata; // R14
      end
      if (hit_route) begin
        route_r <= I_REG_REQ.wdata;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      rdata_r  <= 32'h00000000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= I_REG_REQ.rd ? rd_mux : rdata_r;
      rvalid_r <= I_REG_REQ.rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // host signalling

  assign route.mode         = csie_sig_mode_e'(route_r[`CSIE_RT_MODE_LSB +: 2]);
  assign route.par_term     = route_r[`CSIE_RT_PTERM_LSB +: 3];
  assign route.ser_func_irq = route_r[`CSIE_RT_SFUNC_LSB +: 4];
  assign route.ser_csc_irq  = route_r[`CSIE_RT_SCSC_LSB +: 4];

  csie_host_route u_route (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_csc   (csc_r), // R17
    .i_func  (func_r), // R17
    .i_route (route),
    .o_terms (O_MULTIFUNCTION_TERMINALS) // R02
  );

  assign O_REG_RDATA  = rdata_r;
  assign O_REG_RVALID = rvalid_r;

endmodule

// File: csie_monitor.sv
// assertion checker for the card slot interrupt event block
`timescale 1ns/1ps
module csie_monitor
  import csie_pkg::*;
(
  input  wire logic                 I_CLK,
  input  wire logic                 I_SYS_RST,
  input  csie_pkg::csie_card_s      I_CARD,
  input  csie_pkg::csie_card_type_e I_CARD_TYPE,
  input  wire logic                 I_PWR_CYCLE_DONE,
  input  csie_pkg::csie_req_s       I_REG_REQ,
  input  wire logic [31:0]          O_REG_RDATA,
  input  wire logic                 O_REG_RVALID,
  input  wire logic [6:0]           O_MULTIFUNCTION_TERMINALS
);
  logic [1:0] mode_r;
  logic [2:0] pterm_r;
  wire        rt_wr = I_REG_REQ.wr && I_REG_REQ.addr == 12'h08c;
  wire [6:0]  t     = O_MULTIFUNCTION_TERMINALS;
  wire        fn    = I_CARD.ready_irq && (I_CARD_TYPE == CT_IO16 ||
                      I_CARD_TYPE == CT_CARDBUS);

  // routing shadow kept from the bus, so no internal probe is needed
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mode_r  <= 2'h3;
      pterm_r <= 3'h0;
    end else if (rt_wr) begin
      mode_r  <= I_REG_REQ.wdata[1:0];
      pterm_r <= I_REG_REQ.wdata[6:4];
    end
  end

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence rd_at(logic [11:0] a);
    I_REG_REQ.rd && I_REG_REQ.addr == a;
  endsequence
  // six cycles covers two sync flops plus the route flops
  sequence pend_in(logic [1:0] m);
    (fn && mode_r == m && !rt_wr) [*6];
  endsequence

  rvalid_follow_a: assert property (I_REG_REQ.rd |=> O_REG_RVALID)
    else $error("read without valid");
  rvalid_cause_a: assert property (O_REG_RVALID |-> $past(I_REG_REQ.rd))
    else $error("valid without read");
  unmapped_zero_a: assert property (rd_at(12'h0ff) |=> O_REG_RDATA == 0)
    else $error("unmapped read not zero");
  legacy_width_a: assert property (
    rd_at(12'h004) |=> O_REG_RDATA[31:4] == 28'h0)
    else $error("legacy flag upper bits set");
  mem_nofunc_a: assert property (
    (I_CARD_TYPE == CT_MEM16) [*4] ##0 rd_at(12'h091) |=> O_REG_RDATA == 0)
    else $error("functional flag on memory card");
  func_live_a: assert property (
    fn [*6] ##0 rd_at(12'h091) |=> O_REG_RDATA == 32'h1)
    else $error("functional flag missing");
  serial_low_a: assert property ($fell(t[3]) |-> !t[3] [*5])
    else $error("serial slot too short");
  inta_func_a: assert property (pend_in(2'h0) |-> !t[0])
    else $error("host line idle with request pending");
  par_term_a: assert property (
    pend_in(2'h1) ##0 pterm_r != 3'h0 |-> t[pterm_r])
    else $error("parallel request line idle");
  mode0_quiet_a: assert property (
    (mode_r == 2'h0 && !rt_wr) [*3] |-> t[6:1] == 6'h0)
    else $error("unused terminal driven");
endmodule
//////////////////////////////////////////////////////////////
bind csie_top csie_monitor u_mon (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST),
  .I_CARD(I_CARD), .I_CARD_TYPE(I_CARD_TYPE),
  .I_PWR_CYCLE_DONE(I_PWR_CYCLE_DONE), .I_REG_REQ(I_REG_REQ),
  .O_REG_RDATA(O_REG_RDATA), .O_REG_RVALID(O_REG_RVALID),
  .O_MULTIFUNCTION_TERMINALS(O_MULTIFUNCTION_TERMINALS));

// File: csie_card_model.sv
// behavioural socket card driving the card pins and power status
`timescale 1ns/1ps
module csie_card_model
  import csie_pkg::*;
(
  input  wire logic                 i_clk,
  output csie_pkg::csie_card_s      o_card,
  output csie_pkg::csie_card_type_e o_type,
  output logic                      o_pwr_done
);
  initial begin
    o_card     = '0;
    o_type     = CT_NONE;
    o_pwr_done = 1'b0;
  end
  // a slow card lets some cycles pass before its pins move
  task automatic set_pins(input csie_card_s v, input int dly);
    repeat (dly + 1) @(negedge i_clk);
    o_card = v;
  endtask
  task automatic set_type(input csie_card_type_e ct);
    @(negedge i_clk);
    o_type = ct;
  endtask
  task automatic power_up;
    @(negedge i_clk);
    o_pwr_done = 1'b1;
    @(negedge i_clk);
    o_pwr_done = 1'b0;
  endtask
endmodule

// File: test_card_slot_interrupt_events.sv
// self-checking bench for the card slot interrupt event block
`timescale 1ns/1ps
module test_card_slot_interrupt_events;
  import csie_pkg::*;
  logic            I_CLK = 1'b0;
  logic            I_SYS_RST;
  csie_card_s      card;
  csie_card_type_e ctype;
  logic            pwr_done;
  csie_req_s       req;
  logic [31:0]     rdata;
  logic            rvalid;
  logic [6:0]      terms;
  logic [31:0]     exp_q[$];
  logic [31:0]     msk_q[$];
  logic [31:0]     rnd;
  int              bad_count = 0;
  int              tests_run = 0;
  int              seed      = 32'h436153fb;

  always #12.5 I_CLK = ~I_CLK;

  csie_card_model card_m (.i_clk(I_CLK), .o_card(card), .o_type(ctype),
    .o_pwr_done(pwr_done));
  csie_top DUT (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_CARD(card),
    .I_CARD_TYPE(ctype), .I_PWR_CYCLE_DONE(pwr_done), .I_REG_REQ(req),
    .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .O_MULTIFUNCTION_TERMINALS(terms));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge I_CLK);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge I_CLK);
    req = '{1'b1, 1'b0, a, d};
    @(negedge I_CLK);
    req = '0;
  endtask
  // the expectation is noted before the strobe, the watcher pops it
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(negedge I_CLK);
    req = '{1'b0, 1'b1, a, 32'h0};
    @(negedge I_CLK);
    req = '0;
  endtask

  always @(negedge I_CLK) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(rdata, 32'hx);
      else check(rdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge I_CLK);
    bad_count++;
    end_sim();
  end
  //////////////////////////////////////////////////////////////
  initial begin
    I_SYS_RST = 1'b1;
    req       = '0;
    tick(3);
    I_SYS_RST = 1'b0;
    tick(90);
    rd(12'h004, 32'h0, 32'hf);
    rd(12'h005, 32'h0, 32'hff);
    rd(12'h01e, 32'h0, 32'hff);
    rd(12'h08c, 32'h3, 32'hffff);
    rd(12'h100, 32'h0, 32'hf);
    rd(12'h0ff, 32'h0, 32'hffffffff);
    rnd = $random(seed);
    wr(12'h005, rnd);
    rd(12'h005, rnd, 32'hff);
    wr(12'h104, ~rnd);
    rd(12'h104, ~rnd, 32'hf);
    // memory card: rising then falling edges both count
    card_m.set_type(CT_MEM16);
    card_m.set_pins('{1'b0, 1'b0, 1'b1, 1'b1, 1'b1}, 0);
    tick(5);
    rd(12'h004, 32'h7, 32'hf);
    rd(12'h004, 32'h0, 32'hf);
    rd(12'h091, 32'h0, 32'h1);
    card_m.set_pins('0, 2);
    tick(5);
    rd(12'h004, 32'h7, 32'hf);
    card_m.set_pins('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, 0);
    tick(5);
    rd(12'h100, 32'h6, 32'hf);
    rd(12'h100, 32'h6, 32'hf);
    wr(12'h100, 32'h2);
    rd(12'h100, 32'h4, 32'hf);
    wr(12'h100, 32'h4);
    // i/o card with write-one clearing selected
    card_m.set_type(CT_IO16);
    wr(12'h01e, 32'h4);
    card_m.set_pins('{1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, 0);
    card_m.power_up();
    tick(5);
    rd(12'h004, 32'h9, 32'hf);
    rd(12'h004, 32'h9, 32'hf);
    wr(12'h004, 32'h9);
    rd(12'h004, 32'h0, 32'hf);
    rd(12'h091, 32'h1, 32'h1);
    card_m.set_pins('{1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, 0);
    card_m.set_type(CT_CARDBUS);
    card_m.set_pins('{1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, 1);
    card_m.power_up();
    tick(5);
    rd(12'h100, 32'h9, 32'hf);
    rd(12'h091, 32'h1, 32'h1);
    // parallel host line, masked then enabled then cleared
    wr(12'h100, 32'hf);
    wr(12'h005, 32'h0);
    wr(12'h104, 32'h4);
    wr(12'h08c, 32'h0);
    card_m.set_pins('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, 0);
    tick(6);
    check({25'h0, terms}, 32'h01);
    wr(12'h104, 32'h2);
    tick(3);
    check({25'h0, terms}, 32'h00);
    wr(12'h100, 32'h2);
    tick(3);
    check({25'h0, terms}, 32'h01);
    card_m.set_pins('{1'b0, 1'b1, 1'b0, 1'b0, 1'b1}, 0);
    tick(6);
    check({25'h0, terms}, 32'h00);
    wr(12'h08c, 32'h51);
    tick(6);
    check({25'h0, terms}, 32'h21);
    tick(4);
    check(exp_q.size(), 32'h0);
    end_sim();
  end
endmodule
